// >>> hw/ref_freq_ratio_config.sv
// byte-addressed big endian register bank for reference 0 and 1 rate setup
`timescale 1ns/1ps
`include "ref_freq_ratio_consts.svh"
module ref_freq_ratio_config
  import ref_freq_ratio_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic addr_hit_o,
  input wire logic [15:0] input0_base_rate_i,
  input wire logic [15:0] input0_rate_multiplier_i,
  output logic [15:0] input0_fec_numerator_o,
  output logic [15:0] input0_fec_denominator_o,
  output logic [15:0] input1_base_rate_o,
  output logic [15:0] input1_rate_multiplier_o,
  output logic [15:0] input1_fec_numerator_o,
  output logic [15:0] input1_fec_denominator_o,
  output logic [47:0] input0_freq_hz_o,
  output logic [47:0] input1_freq_hz_o,
  output logic [1:0] freq_valid_o
);
  // byte image of 0x14..0x1f, index 0 is 0x14
  localparam int NBYTES = 12;
  reg_byte_t mem_reg [NBYTES];
  reg_byte_t mem_next [NBYTES];
  reg_byte_t rdata_reg, rdata_next;
  logic [1:0] dirty_reg, dirty_next, valid_reg, valid_next;
  logic [1:0] busy, done, start;
  logic [47:0] freq [2];
  // ref0 base and multiplier come from the parent; a registered copy lets a change re-arm the run
  half_word_t base0_seen_reg, base0_seen_next, mult0_seen_reg, mult0_seen_next;
  logic port0_moved;
  logic [63:0] prod0, prod1, back0, back1;

  function automatic logic in_bank(input logic [7:0] a);
    return (a >= `OFS_INPUT0_FEC_RATIO) && (a <= `OFS_LAST);
  endfunction
  function automatic logic [3:0] byte_index(input logic [7:0] a);
    return 4'(a - `OFS_INPUT0_FEC_RATIO);
  endfunction
  function automatic reg_byte_t reset_byte(input int i);
    logic [95:0] img;
    // [R7] power-up image, msb first as stored
    img = {`RST_FEC_RATIO, `RST_INPUT1_BASE_RATE, `RST_INPUT1_RATE_MULTIPLIER, `RST_FEC_RATIO};
    return img[95-8*i -: 8];
  endfunction

  // [R5] most significant byte at the lowest address
  assign input0_fec_numerator_o = {mem_reg[0], mem_reg[1]}; // [R1]
  assign input0_fec_denominator_o = {mem_reg[2], mem_reg[3]}; // [R1]
  assign input1_base_rate_o = {mem_reg[4], mem_reg[5]}; // [R5]
  assign input1_rate_multiplier_o = {mem_reg[6], mem_reg[7]}; // [R5]
  assign input1_fec_numerator_o = {mem_reg[8], mem_reg[9]}; // [R1]
  assign input1_fec_denominator_o = {mem_reg[10], mem_reg[11]}; // [R1]

  always_comb begin
    for (int i = 0; i < NBYTES; i++) begin
      mem_next[i] = mem_reg[i];
    end
    rdata_next = rdata_reg;
    base0_seen_next = input0_base_rate_i;
    mult0_seen_next = input0_rate_multiplier_i;
    if (wr_en_i && in_bank(addr_i)) begin
      mem_next[byte_index(addr_i)] = wdata_i;
    end
    if (rd_en_i) begin
      rdata_next = in_bank(addr_i) ? mem_reg[byte_index(addr_i)] : 8'h00;
    end
  end

  // a reference is recomputed after any write to its bytes; a write during a
  // run re-arms it so the result never lags the registers
  always_comb begin
    dirty_next = dirty_reg;
    valid_next = valid_reg;
    for (int r = 0; r < 2; r++) begin
      if (start[r]) dirty_next[r] = 1'b0;
      // a result from inputs that moved mid-run stays hidden until the rerun ends
      if (done[r] && !dirty_reg[r]) valid_next[r] = 1'b1;
    end
    if (port0_moved) begin // [R9]
      dirty_next[0] = 1'b1;
      valid_next[0] = 1'b0;
    end
    if (wr_en_i && in_bank(addr_i)) begin
      if (byte_index(addr_i) < 4'h4) begin
        dirty_next[0] = 1'b1;
        valid_next[0] = 1'b0;
      end else begin
        dirty_next[1] = 1'b1;
        valid_next[1] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NBYTES; i++) begin
        mem_reg[i] <= reset_byte(i); // [R7]
      end
      rdata_reg <= 8'h00;
      dirty_reg <= 2'h3;
      valid_reg <= 2'h0;
      base0_seen_reg <= `RST_INPUT0_BASE_RATE;
      mult0_seen_reg <= `RST_INPUT0_RATE_MULTIPLIER;
    end else begin
      for (int i = 0; i < NBYTES; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      rdata_reg <= rdata_next;
      dirty_reg <= dirty_next;
      valid_reg <= valid_next;
      base0_seen_reg <= base0_seen_next;
      mult0_seen_reg <= mult0_seen_next;
    end
  end

  assign start = dirty_reg & ~busy;
  assign port0_moved = (input0_base_rate_i != base0_seen_reg) || (input0_rate_multiplier_i != mult0_seen_reg);

  // [R9] one calculator per reference, same code
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ref
      ref_rate_calc #(.FIELD_W(16)) u_calc (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(start[g]),
        .base_rate_i(g == 0 ? base0_seen_reg : input1_base_rate_o),
        .rate_multiplier_i(g == 0 ? mult0_seen_reg : input1_rate_multiplier_o),
        .fec_numerator_i(g == 0 ? input0_fec_numerator_o : input1_fec_numerator_o),
        .fec_denominator_i(g == 0 ? input0_fec_denominator_o : input1_fec_denominator_o),
        .freq_hz_o(freq[g]),
        .busy_o(busy[g]),
        .done_o(done[g])
      ); // [R2] [R9]
    end
  endgenerate

  assign input0_freq_hz_o = freq[0];
  assign input1_freq_hz_o = freq[1];
  assign freq_valid_o = valid_reg & ~dirty_reg;
  assign rdata_o = rdata_reg;
  assign addr_hit_o = in_bank(addr_i);
  // helper terms for the result checks only
  assign prod0 = 64'(base0_seen_reg) * 64'(mult0_seen_reg) * 64'(input0_fec_numerator_o);
  assign prod1 = 64'(input1_base_rate_o) * 64'(input1_rate_multiplier_o) * 64'(input1_fec_numerator_o);
  assign back0 = 64'(input0_freq_hz_o) * 64'(input0_fec_denominator_o);
  assign back1 = 64'(input1_freq_hz_o) * 64'(input1_fec_denominator_o);

  AST_RESET_RATIO: assert property (@(posedge clk_sys_i) // [R7]
    $rose(resetn_i) |-> ({input0_fec_numerator_o, input0_fec_denominator_o} == `RST_FEC_RATIO
      && {input1_fec_numerator_o, input1_fec_denominator_o} == `RST_FEC_RATIO
      && input1_base_rate_o == `RST_INPUT1_BASE_RATE && input1_rate_multiplier_o == `RST_INPUT1_RATE_MULTIPLIER))
    else $error("register bank not at its defaults after reset");
  AST_BIG_ENDIAN_HI: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R5]
    (wr_en_i && addr_i == `OFS_INPUT1_BASE_RATE) |=> (input1_base_rate_o[15:8] == $past(wdata_i)))
    else $error("high byte not at low address");
  AST_BIG_ENDIAN_LO: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R5]
    (wr_en_i && addr_i == `OFS_INPUT1_BASE_RATE + 8'h01) |=> (input1_base_rate_o[7:0] == $past(wdata_i)))
    else $error("low byte not at high address");
  AST_DENOM_LOW: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R1]
    (wr_en_i && addr_i == `OFS_LAST) |=> (input1_fec_denominator_o[7:0] == $past(wdata_i)))
    else $error("denominator not in low half");
  AST_NUMER_HIGH: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R1]
    (wr_en_i && addr_i == `OFS_INPUT0_FEC_RATIO) |=> (input0_fec_numerator_o[15:8] == $past(wdata_i)))
    else $error("numerator not in high half");
  AST_READBACK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R5]
    (rd_en_i && !wr_en_i && addr_i == `OFS_INPUT1_RATE_MULTIPLIER) |=> (rdata_o == input1_rate_multiplier_o[15:8]))
    else $error("readback mismatch");
  AST_UNMAPPED_ZERO: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R5]
    (rd_en_i && !in_bank(addr_i)) |=> (rdata_o == 8'h00))
    else $error("unmapped read not zero");
  AST_WRITE_INVALIDATES: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R9]
    (wr_en_i && addr_i == `OFS_INPUT1_FEC_RATIO) |=> !freq_valid_o[1])
    else $error("stale frequency flagged valid");
  AST_STRAY_WRITE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R5]
    (wr_en_i && !in_bank(addr_i)) |=> ({input0_fec_numerator_o, input0_fec_denominator_o, input1_base_rate_o,
      input1_rate_multiplier_o, input1_fec_numerator_o, input1_fec_denominator_o} == $past({input0_fec_numerator_o,
      input0_fec_denominator_o, input1_base_rate_o, input1_rate_multiplier_o, input1_fec_numerator_o,
      input1_fec_denominator_o})))
    else $error("write outside the bank changed a field");
  AST_VALID_IDLE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R2]
    (freq_valid_o & busy) == 2'h0)
    else $error("frequency flagged valid while it is being recomputed");
  AST_PORT_TRACKED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R9]
    port0_moved |=> !freq_valid_o[0])
    else $error("reference 0 result kept valid after its base or multiplier moved");
  AST_RESULT0_BOUNDS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R2] [R9]
    (freq_valid_o[0] && input0_fec_denominator_o != 16'h0000)
    |-> (back0 <= prod0 && prod0 - back0 < 64'(input0_fec_denominator_o)))
    else $error("reference 0 rate is not the quotient of its terms");
  AST_RESULT1_BOUNDS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R2] [R9]
    (freq_valid_o[1] && input1_fec_denominator_o != 16'h0000)
    |-> (back1 <= prod1 && prod1 - back1 < 64'(input1_fec_denominator_o)))
    else $error("reference 1 rate is not the quotient of its terms");
  AST_ZERO_DENOM: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R2]
    (freq_valid_o[1] && input1_fec_denominator_o == 16'h0000) |-> (input1_freq_hz_o == 48'h0))
    else $error("zero denominator did not give a zero rate");
endmodule

// >>> hw/ref_freq_ratio_consts.svh
// offsets, reset values and field positions of the reference rate registers
// Behaviour
// [R1] ratio word: denominator low, numerator high
// [R2] expected rate is base times multiplier times ratio
// [R3] software leaves ratio at one without fec
// [R4] software programs base rate from supported codes
// [R5] multi-byte registers are big endian
// [R6] software picks multiplier matching actual frequency
// [R7] reset loads ratio one, 40 kHz, 486
// [R8] software locks updates around sticky writes
// [R9] both references share layout and computation; ref0 base and multiplier are input ports, only its ratio is in the bank
`ifndef REF_FREQ_RATIO_CONSTS_SVH
`define REF_FREQ_RATIO_CONSTS_SVH
`define OFS_INPUT0_FEC_RATIO 8'h14
`define OFS_INPUT1_BASE_RATE 8'h18
`define OFS_INPUT1_RATE_MULTIPLIER 8'h1a
`define OFS_INPUT1_FEC_RATIO 8'h1c
`define OFS_LAST 8'h1f
`define RST_FEC_RATIO 32'h00010001
`define RST_INPUT1_BASE_RATE 16'h9c40
`define RST_INPUT1_RATE_MULTIPLIER 16'h01e6
`define RST_INPUT0_BASE_RATE 16'h9c40
`define RST_INPUT0_RATE_MULTIPLIER 16'h0f30
`define FEC_DENOMINATOR_LSB 0
`define FEC_NUMERATOR_LSB 16
`endif

// >>> hw/ref_freq_ratio_pkg.sv
// types shared by the reference rate register bank
package ref_freq_ratio_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [15:0] half_word_t;
  typedef logic [31:0] ratio_word_t;
  typedef enum logic [1:0] {CALC_IDLE, CALC_MUL, CALC_DIV} calc_state_t;
endpackage

// >>> hw/ref_rate_calc.sv
// per-reference expected frequency: base * multiplier * numerator / denominator
`timescale 1ns/1ps
`include "ref_freq_ratio_consts.svh"
module ref_rate_calc
  import ref_freq_ratio_pkg::*;
#(
  parameter int FIELD_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [FIELD_W-1:0] base_rate_i,
  input wire logic [FIELD_W-1:0] rate_multiplier_i,
  input wire logic [FIELD_W-1:0] fec_numerator_i,
  input wire logic [FIELD_W-1:0] fec_denominator_i,
  output logic [3*FIELD_W-1:0] freq_hz_o,
  output logic busy_o,
  output logic done_o
);
  localparam int PW = 3 * FIELD_W;
  localparam int CW = $clog2(PW + 1);
  if (FIELD_W < 1) begin : g_bad_width
    $error("field width must be positive");
  end
  calc_state_t state_reg, state_next;
  logic [PW-1:0] rem_reg, rem_next, quo_reg, quo_next, freq_reg, freq_next;
  logic [FIELD_W-1:0] den_reg, den_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic [PW:0] trial;
  // restoring division, one quotient bit a cycle, keeps area to one subtractor
  always_comb begin
    state_next = state_reg;
    rem_next = rem_reg;
    quo_next = quo_reg;
    den_next = den_reg;
    cnt_next = cnt_reg;
    freq_next = freq_reg;
    done_next = 1'b0;
    trial = {rem_reg, quo_reg[PW-1]} - {{(PW+1-FIELD_W){1'b0}}, den_reg};
    case (state_reg)
      CALC_IDLE: begin
        if (start_i) begin
          state_next = CALC_MUL;
          den_next = fec_denominator_i;
        end
      end
      CALC_MUL: begin
        // [R2] product of the three numerator terms
        quo_next = PW'(base_rate_i) * PW'(rate_multiplier_i) * PW'(fec_numerator_i);
        rem_next = '0;
        cnt_next = CW'(PW);
        state_next = CALC_DIV;
      end
      CALC_DIV: begin
        if (den_reg == '0) begin
          // zero denominator gives zero rather than hanging
          freq_next = '0;
          done_next = 1'b1;
          state_next = CALC_IDLE;
        end else begin
          if (!trial[PW]) begin
            rem_next = trial[PW-1:0];
            quo_next = {quo_reg[PW-2:0], 1'b1};
          end else begin
            rem_next = {rem_reg[PW-2:0], quo_reg[PW-1]};
            quo_next = {quo_reg[PW-2:0], 1'b0};
          end
          cnt_next = cnt_reg - CW'(1);
          if (cnt_reg == CW'(1)) begin
            freq_next = quo_next; // [R2]
            done_next = 1'b1;
            state_next = CALC_IDLE;
          end
        end
      end
      default: state_next = CALC_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= CALC_IDLE;
      rem_reg <= '0;
      quo_reg <= '0;
      den_reg <= '0;
      cnt_reg <= '0;
      freq_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      den_reg <= den_next;
      cnt_reg <= cnt_next;
      freq_reg <= freq_next;
      done_reg <= done_next;
    end
  end
  assign freq_hz_o = freq_reg;
  assign busy_o = (state_reg != CALC_IDLE);
  assign done_o = done_reg;
  AST_DONE_BOUNDED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R2]
    (state_reg == CALC_IDLE && start_i) |-> ##[2:60] done_reg)
    else $error("rate computation did not finish in time");
  // the product is formed from the inputs of the multiply cycle, so compare against those
  AST_ONE_RATIO: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // [R2]
    (state_reg == CALC_MUL && fec_numerator_i == FIELD_W'(1) && den_reg == FIELD_W'(1))
    |=> (quo_reg == PW'($past(base_rate_i)) * PW'($past(rate_multiplier_i))))
    else $error("unit ratio product wrong");
endmodule

// >>> verif/test_ref_freq_ratio_config.sv
// self-checking bench for the reference rate register bank
`timescale 1ns/1ps
module test_ref_freq_ratio_config;
  import ref_freq_ratio_pkg::*;
  logic clk_sys_i, resetn_i, wr_en_i, rd_en_i, addr_hit_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [15:0] base0_i, mult0_i, num0, den0, base1, mult1, num1, den1;
  logic [47:0] f0, f1;
  logic [1:0] fv;
  logic [31:0] v, u;
  int seed, n_fail, cmp_count, cycles;

  ref_freq_ratio_config ref_freq_ratio_config_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .addr_hit_o(addr_hit_o),
    .input0_base_rate_i(base0_i), .input0_rate_multiplier_i(mult0_i),
    .input0_fec_numerator_o(num0), .input0_fec_denominator_o(den0),
    .input1_base_rate_o(base1), .input1_rate_multiplier_o(mult1),
    .input1_fec_numerator_o(num1), .input1_fec_denominator_o(den1),
    .input0_freq_hz_o(f0), .input1_freq_hz_o(f1), .freq_valid_o(fv));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // a hang counts as a mismatch and still reaches the report
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  function automatic logic [47:0] freq(input logic [15:0] b, k, m, n);
    logic [63:0] p;
    p = 64'(b) * 64'(k) * 64'(m);
    return (n == 16'h0) ? 48'h0 : 48'(p / 64'(n));
  endfunction

  // base rates software may program
  function automatic logic [15:0] base_code(input logic [31:0] r);
    case (r % 32'h9)
      32'h0: return 16'h03e8;
      32'h1: return 16'h07d0;
      32'h2: return 16'h1388;
      32'h3: return 16'h186a;
      32'h4: return 16'h1f40;
      32'h5: return 16'h2710;
      32'h6: return 16'h30d4;
      32'h7: return 16'h61a8;
      default: return 16'h9c40;
    endcase
  endfunction

  function automatic logic in_map(input logic [7:0] a);
    return (a >= 8'h14) && (a <= 8'h1f);
  endfunction

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    cmp_count++;
    if (rdata_o !== e) begin
      n_fail++;
      $display("unexpected rdata at %h: expected %h seen %h", a, e, rdata_o);
    end
  endtask

  task automatic chk_out(input string name, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask

  // bytes go out back to back, most significant first
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int nb);
    wr_en_i = 1'b1;
    for (int i = 0; i < nb; i++) begin
      addr_i = a + 8'(i);
      wdata_i = 8'(d >> (8 * (nb - 1 - i)));
      @(negedge clk_sys_i);
    end
    wr_en_i = 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input int nb);
    for (int i = 0; i < nb; i++) begin
      addr_i = a + 8'(i);
      rd_en_i = 1'b1;
      @(negedge clk_sys_i);
      rd_en_i = 1'b0;
      chk_rd(a + 8'(i), 8'(d >> (8 * (nb - 1 - i))));
      chk_out("addr_hit", 48'(in_map(a + 8'(i))), 48'(addr_hit_o));
      @(negedge clk_sys_i);
    end
  endtask

  task automatic wait_freq(input int r, input logic [47:0] e);
    int n;
    n = 0;
    // a write during a run costs a second full run, about a hundred cycles
    while (fv[r] !== 1'b1 && n < 120) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk_out("freq_valid", 48'h1, 48'(fv[r]));
    chk_out("freq_hz", e, (r == 0) ? f0 : f1);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    seed = 2078;
    n_fail = 0;
    cmp_count = 0;
    cycles = 0;
    resetn_i = 1'b0;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    base0_i = 16'h9c40;
    mult0_i = 16'h0f30;
    repeat (20) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    @(negedge clk_sys_i);
    rd(8'h14, 32'h00010001, 4);
    rd(8'h18, 32'h9c40, 2);
    rd(8'h1a, 32'h01e6, 2);
    rd(8'h1c, 32'h00010001, 4);
    chk_out("input1_rate_multiplier", 48'h01e6, 48'(mult1));
    wait_freq(1, freq(16'h9c40, 16'h01e6, 16'h1, 16'h1));
    wait_freq(0, freq(16'h9c40, 16'h0f30, 16'h1, 16'h1));
    wr(8'h14, 32'h00ff00ed, 4);
    chk_out("input0_fec_numerator", 48'h00ff, 48'(num0));
    chk_out("input0_fec_denominator", 48'h00ed, 48'(den0));
    wait_freq(0, freq(16'h9c40, 16'h0f30, 16'h00ff, 16'h00ed));
    // one burst runs across the base and multiplier registers
    wr(8'h18, 32'h61a8186a, 4);
    chk_out("input1_base_rate", 48'h61a8, 48'(base1));
    wr(8'h1c, 32'h41be3b80, 4);
    chk_out("input1_fec_numerator", 48'h41be, 48'(num1));
    chk_out("input1_fec_denominator", 48'h3b80, 48'(den1));
    wait_freq(1, freq(16'h61a8, 16'h186a, 16'h41be, 16'h3b80));
    // no latched status lives in this bank, so no update lock is written
    wr(8'h20, 32'hffff, 2);
    wr(8'h12, 32'hff, 1);
    rd(8'h20, 32'h0, 2);
    rd(8'h12, 32'h0, 1);
    rd(8'h18, 32'h61a8186a, 4);
    wr(8'h1e, 32'h0, 2);
    wait_freq(1, 48'h0);
    for (int t = 0; t < 12; t++) begin
      v = $random(seed);
      u = $random(seed);
      u[31:16] = base_code(u);
      if (t % 2 == 0) begin
        base0_i = u[31:16];
        mult0_i = u[15:0];
        wr(8'h14, v, 4);
        chk_out("input0_fec_numerator", 48'(v[31:16]), 48'(num0));
        wait_freq(0, freq(u[31:16], u[15:0], v[31:16], v[15:0]));
        rd(8'h14, v, 4);
      end else begin
        wr(8'h18, u, 4);
        chk_out("input1_base_rate", 48'(u[31:16]), 48'(base1));
        wr(8'h1c, v, 4);
        chk_out("input1_fec_denominator", 48'(v[15:0]), 48'(den1));
        wait_freq(1, freq(u[31:16], u[15:0], v[31:16], v[15:0]));
        rd(8'h1c, v, 4);
      end
    end
    resetn_i = 1'b0;
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    @(negedge clk_sys_i);
    rd(8'h14, 32'h00010001, 4);
    rd(8'h18, 32'h9c4001e6, 4);
    rd(8'h1c, 32'h00010001, 4);
    wait_freq(1, freq(16'h9c40, 16'h01e6, 16'h1, 16'h1));
    wait_freq(0, freq(base0_i, mult0_i, 16'h1, 16'h1));
    summarize();
  end
endmodule
